// file: verilog/srs_defs.svh
// Register space constants for the scratchpad register space block
// What this block does
// - Every bit of scratchpad bytes 20h to 2Fh can be read and written one at a time.
// - Bit or byte access is chosen by the access kind given by the instruction, not by the address.
// - Peripheral register bit access is allowed only at addresses whose low hex digit is 0 or 8.
// - Four banks of eight working registers live in the lower scratchpad and the selected bank is used.
// - The active bank comes from bits 4 and 3 of the program status word at D0h.
// - A working register's contents can address the upper 128 scratchpad bytes indirectly.
// - Direct accesses to 80h through FFh go to the peripheral registers, not to scratchpad.
// - Calls and interrupt entries save the return address onto the scratchpad stack.
// - The stack pointer at 81h resets to 07h and software can write it.
// - The stack pointer marks the last written byte, so a push writes one above it.
// - The stack pointer rises by the bytes pushed and falls by the bytes popped.
// - Scratchpad 00h to 7Fh is reachable directly, the upper half only indirectly.
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH
`define SRS_RAM_DEPTH       256
`define SRS_BITRAM_BASE     8'h20
`define SRS_BITRAM_LAST     8'h2f
`define SRS_SFR_BASE        8'h80
`define SRS_SP_RESET        8'h07
`define SRS_ADDR_SP         8'h81
`define SRS_ADDR_DP0LO      8'h82
`define SRS_ADDR_DP0HI      8'h83
`define SRS_ADDR_DP1LO      8'h84
`define SRS_ADDR_DP1HI      8'h85
`define SRS_ADDR_DPSEL      8'h86
`define SRS_ADDR_PWR        8'h87
`define SRS_ADDR_TCTL       8'h88
`define SRS_ADDR_TMODE      8'h89
`define SRS_ADDR_T0LO       8'h8a
`define SRS_ADDR_T1LO       8'h8b
`define SRS_ADDR_T0HI       8'h8c
`define SRS_ADDR_T1HI       8'h8d
`define SRS_ADDR_CKCTL      8'h8e
`define SRS_ADDR_PORT1      8'h90
`define SRS_ADDR_EXIRQ      8'h91
`define SRS_ADDR_SCTL0      8'h98
`define SRS_ADDR_SER0BUF    8'h99
`define SRS_ADDR_PORT2      8'ha0
`define SRS_ADDR_IRQEN      8'ha8
`define SRS_ADDR_SADR0      8'ha9
`define SRS_ADDR_PORT3      8'hb0
`define SRS_ADDR_IRQPRI     8'hb8
`define SRS_ADDR_SMSK0      8'hb9
`define SRS_ADDR_STAT       8'hc5
`define SRS_ADDR_T2CTL      8'hc8
`define SRS_ADDR_T2MODE     8'hc9
`define SRS_ADDR_RCL2       8'hca
`define SRS_ADDR_RCH2       8'hcb
`define SRS_ADDR_T2LO       8'hcc
`define SRS_ADDR_T2HI       8'hcd
`define SRS_ADDR_PSW        8'hd0
`define SRS_ADDR_WDCTL      8'hd8
`define SRS_ADDR_ACC        8'he0
`define SRS_ADDR_EXIRQEN    8'he8
`define SRS_ADDR_BREG       8'hf0
`define SRS_ADDR_EXIRQPRI   8'hf8
`define SRS_PSW_BANK_HI     4
`define SRS_PSW_BANK_LO     3
`define SRS_BANK_SHIFT      3
`define SRS_BITIDX_MSB      2
`define SRS_RESET_PORT      8'hff
`define SRS_RESET_CKCTL     8'h01
`define SRS_RESET_STAT      8'h1f
`define SRS_RESET_ZERO      8'h00
`endif

// file: verilog/srs_pkg.sv
// Types for the scratchpad register space block
package srs_pkg;
   typedef enum logic [2:0] {
      SRS_OP_NONE   = 3'b000,
      SRS_OP_DIRECT = 3'b001,
      SRS_OP_BIT    = 3'b010,
      SRS_OP_INDIR  = 3'b011,
      SRS_OP_REG    = 3'b100,
      SRS_OP_PUSH   = 3'b101,
      SRS_OP_POP    = 3'b110
   } srs_op_e;
   typedef logic [7:0] srs_byte_t;
endpackage

// file: verilog/srs_scratch_ram.sv
// 256-byte scratchpad RAM held in flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "srs_defs.svh"
module srs_scratch_ram
   import srs_pkg::*;
(
   // Clock and reset
   input  wire logic      clk_i,
   input  wire logic      rst_n_i,
   // Write port
   input  wire logic      we_i,
   input  wire srs_byte_t waddr_i,
   input  wire srs_byte_t wdata_i,
   // Read ports
   input  wire srs_byte_t raddr_a_i,
   output srs_byte_t      rdata_a_o,
   input  wire srs_byte_t raddr_b_i,
   output srs_byte_t      rdata_b_o
);
   srs_byte_t mem_q [`SRS_RAM_DEPTH];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < `SRS_RAM_DEPTH; i++) begin
            mem_q[i] <= `SRS_RESET_ZERO;
         end
      end else if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   assign rdata_a_o = mem_q[raddr_a_i];
   assign rdata_b_o = mem_q[raddr_b_i];
endmodule
`default_nettype wire

// file: verilog/srs_sfr_file.sv
// Peripheral register file at 80h-FFh with byte and bit writes
`timescale 1ns/1ps
`default_nettype none
`include "srs_defs.svh"
module srs_sfr_file
   import srs_pkg::*;
(
   // Clock and reset
   input  wire logic      clk_i,
   input  wire logic      rst_n_i,
   // Write port
   input  wire logic      we_i,
   input  wire srs_byte_t addr_i,
   input  wire srs_byte_t wdata_i,
   // Read port and mapping
   output srs_byte_t      rdata_o,
   output logic           hit_o,
   // Bank select bits
   output logic [1:0]     bank_o
);
   srs_byte_t regs_q [`SRS_SFR_BASE:8'hff];

   function automatic logic is_mapped(input srs_byte_t a);
      unique case (a)
         `SRS_ADDR_DP0LO, `SRS_ADDR_DP0HI, `SRS_ADDR_DP1LO, `SRS_ADDR_DP1HI,
         `SRS_ADDR_DPSEL, `SRS_ADDR_PWR, `SRS_ADDR_TCTL, `SRS_ADDR_TMODE,
         `SRS_ADDR_T0LO, `SRS_ADDR_T1LO, `SRS_ADDR_T0HI, `SRS_ADDR_T1HI,
         `SRS_ADDR_CKCTL, `SRS_ADDR_PORT1, `SRS_ADDR_EXIRQ, `SRS_ADDR_SCTL0,
         `SRS_ADDR_SER0BUF, `SRS_ADDR_PORT2, `SRS_ADDR_IRQEN, `SRS_ADDR_SADR0,
         `SRS_ADDR_PORT3, `SRS_ADDR_IRQPRI, `SRS_ADDR_SMSK0, `SRS_ADDR_T2CTL,
         `SRS_ADDR_T2MODE, `SRS_ADDR_RCL2, `SRS_ADDR_RCH2, `SRS_ADDR_T2LO,
         `SRS_ADDR_T2HI, `SRS_ADDR_PSW, `SRS_ADDR_WDCTL, `SRS_ADDR_ACC,
         `SRS_ADDR_EXIRQEN, `SRS_ADDR_BREG, `SRS_ADDR_EXIRQPRI: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   function automatic srs_byte_t reset_of(input srs_byte_t a);
      unique case (a)
         `SRS_ADDR_PORT1, `SRS_ADDR_PORT2, `SRS_ADDR_PORT3: reset_of = `SRS_RESET_PORT;
         `SRS_ADDR_CKCTL: reset_of = `SRS_RESET_CKCTL;
         `SRS_ADDR_STAT:  reset_of = `SRS_RESET_STAT;
         default:         reset_of = `SRS_RESET_ZERO;
      endcase
   endfunction

   // Stack pointer is kept in the top module
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = int'(`SRS_SFR_BASE); i < `SRS_RAM_DEPTH; i++) begin
            regs_q[i] <= reset_of(8'(i));
         end
      end else if (we_i && is_mapped(addr_i)) begin
         regs_q[addr_i] <= wdata_i;
      end
   end

   assign hit_o   = is_mapped(addr_i) || (addr_i == `SRS_ADDR_STAT);
   assign rdata_o = hit_o ? regs_q[addr_i] : `SRS_RESET_ZERO;
   assign bank_o  = {regs_q[`SRS_ADDR_PSW][`SRS_PSW_BANK_HI],
                     regs_q[`SRS_ADDR_PSW][`SRS_PSW_BANK_LO]};
endmodule
`default_nettype wire

// file: verilog/srs_top.sv
// Scratchpad register space: RAM, working banks, stack and peripheral window
`timescale 1ns/1ps
`default_nettype none
`include "srs_defs.svh"
module srs_top
   import srs_pkg::*;
(
   // Clock and reset
   input  wire logic      CORE_CLK_I,
   input  wire logic      RSTN_I,
   // Access request from execution unit
   input  wire srs_op_e   OP_I,
   input  wire logic      WR_I,
   input  wire srs_byte_t ADDR_I,
   input  wire logic [2:0] REG_I,
   input  wire srs_byte_t WDATA_I,
   input  wire logic      BIT_I,
   // Answer
   output srs_byte_t      RDATA_O,
   output logic           RBIT_O,
   output logic           ERR_O,
   // State
   output srs_byte_t      SP_O,
   output logic [1:0]     BANK_O
);
   ////////////////////////////////////////////////////////////////////////
   srs_byte_t sp_q;
   srs_byte_t sp_d;
   srs_byte_t ram_a;
   srs_byte_t ram_b;
   srs_byte_t ram_rd_a;
   srs_byte_t ram_rd_b;
   srs_byte_t ram_wa;
   srs_byte_t ram_wd;
   logic      ram_we;
   srs_byte_t sfr_addr;
   srs_byte_t sfr_rd;
   srs_byte_t sfr_wd;
   logic      sfr_we;
   logic      sfr_hit;
   logic [1:0] bank;
   srs_byte_t cur_byte;
   logic [2:0] bidx;
   logic      bit_ok;
   logic      is_sp;
   srs_byte_t rdata_d;
   logic      rbit_d;
   logic      err_d;

   function automatic srs_byte_t work_addr(input logic [1:0] b, input logic [2:0] r);
      work_addr = {3'b000, b, r};
   endfunction

   function automatic srs_byte_t set_bit(input srs_byte_t v, input logic [2:0] i, input logic b);
      srs_byte_t t;
      t    = v;
      t[i] = b;
      set_bit = t;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bit address decode
   assign bidx = ADDR_I[`SRS_BITIDX_MSB:0];
   always_comb begin
      if (OP_I == SRS_OP_BIT && ADDR_I[7]) begin
         sfr_addr = {ADDR_I[7:3], 3'b000};
      end else begin
         sfr_addr = ADDR_I;
      end
   end
   assign bit_ok = ADDR_I[7] ? sfr_hit : 1'b1;

   // Bit byte address in RAM: 20h + addr/8
   always_comb begin
      ram_a = ADDR_I;
      unique case (OP_I)
         SRS_OP_BIT:    ram_a = 8'(`SRS_BITRAM_BASE + {4'h0, ADDR_I[6:3]});
         SRS_OP_INDIR:  ram_a = ram_rd_b;
         SRS_OP_REG:    ram_a = work_addr(bank, REG_I);
         SRS_OP_PUSH:   ram_a = 8'(sp_q + 8'h01);
         SRS_OP_POP:    ram_a = sp_q;
         default:       ram_a = ADDR_I;
      endcase
   end
   assign ram_b = work_addr(bank, REG_I);

   assign is_sp = (sfr_addr == `SRS_ADDR_SP);

   srs_scratch_ram u_ram (
      .clk_i     (CORE_CLK_I),
      .rst_n_i   (RSTN_I),
      .we_i      (ram_we),
      .waddr_i   (ram_wa),
      .wdata_i   (ram_wd),
      .raddr_a_i (ram_a),
      .rdata_a_o (ram_rd_a),
      .raddr_b_i (ram_b),
      .rdata_b_o (ram_rd_b)
   );

   srs_sfr_file u_sfr (
      .clk_i   (CORE_CLK_I),
      .rst_n_i (RSTN_I),
      .we_i    (sfr_we),
      .addr_i  (sfr_addr),
      .wdata_i (sfr_wd),
      .rdata_o (sfr_rd),
      .hit_o   (sfr_hit),
      .bank_o  (bank)
   );

   ////////////////////////////////////////////////////////////////////////
   // Routing of each access kind
   always_comb begin
      ram_we   = 1'b0;
      ram_wa   = ram_a;
      ram_wd   = WDATA_I;
      sfr_we   = 1'b0;
      sfr_wd   = WDATA_I;
      cur_byte = ram_rd_a;
      err_d    = 1'b0;
      unique case (OP_I)
         SRS_OP_DIRECT: begin
            if (ADDR_I[7]) begin
               cur_byte = is_sp ? sp_q : sfr_rd;
               sfr_we   = WR_I && !is_sp;
               err_d    = !sfr_hit && !is_sp;
            end else begin
               ram_we   = WR_I;
            end
         end
         SRS_OP_BIT: begin
            if (ADDR_I[7]) begin
               cur_byte = sfr_rd;
               sfr_wd   = set_bit(sfr_rd, bidx, BIT_I);
               sfr_we   = WR_I && bit_ok;
               err_d    = !bit_ok;
            end else begin
               ram_wd   = set_bit(ram_rd_a, bidx, BIT_I);
               ram_we   = WR_I;
            end
         end
         SRS_OP_INDIR, SRS_OP_REG: begin
            ram_we = WR_I;
         end
         SRS_OP_PUSH: begin
            ram_we = 1'b1;
         end
         SRS_OP_POP, SRS_OP_NONE: begin
            ram_we = 1'b0;
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Stack pointer
   always_comb begin
      sp_d = sp_q;
      if (OP_I == SRS_OP_PUSH) begin
         sp_d = 8'(sp_q + 8'h01);
      end else if (OP_I == SRS_OP_POP) begin
         sp_d = 8'(sp_q - 8'h01);
      end else if (OP_I == SRS_OP_DIRECT && WR_I && is_sp) begin
         sp_d = WDATA_I;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RSTN_I) begin
         sp_q <= `SRS_SP_RESET;
      end else begin
         sp_q <= sp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered answer
   assign rdata_d = cur_byte;
   assign rbit_d  = (OP_I == SRS_OP_BIT) ? cur_byte[bidx] : 1'b0;

   always_ff @(posedge CORE_CLK_I) begin
      if (!RSTN_I) begin
         RDATA_O <= `SRS_RESET_ZERO;
         RBIT_O  <= 1'b0;
         ERR_O   <= 1'b0;
      end else begin
         RDATA_O <= rdata_d;
         RBIT_O  <= rbit_d;
         ERR_O   <= err_d;
      end
   end

   assign SP_O   = sp_q;
   assign BANK_O = bank;
endmodule
`default_nettype wire

// file: verification/srs_top_chk.sv
// Port-level assertions for the scratchpad register space
`timescale 1ns/1ps
`default_nettype none
module srs_top_chk
   import srs_pkg::*;
(
   // Clock, reset and request
   input wire logic       CORE_CLK_I,
   input wire logic       RSTN_I,
   input wire srs_op_e    OP_I,
   input wire logic       WR_I,
   input wire srs_byte_t  ADDR_I,
   input wire srs_byte_t  WDATA_I,
   // Answer and state
   input wire logic       RBIT_O,
   input wire logic       ERR_O,
   input wire srs_byte_t  SP_O,
   input wire logic [1:0] BANK_O
);
   logic       psw_wr_q;
   logic [1:0] bank_wr_q;
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);
   ////////////////////////////////////////////////////////////////
   // Writes that may reach the bank-select bits
   always_ff @(posedge CORE_CLK_I) begin
      psw_wr_q  <= WR_I && ((OP_I == SRS_OP_DIRECT && ADDR_I == 8'hd0) ||
                            (OP_I == SRS_OP_BIT && ADDR_I[7:3] == 5'h1a));
      bank_wr_q <= WDATA_I[4:3];
   end
   ////////////////////////////////////////////////////////////////
   a_sp_reset: assert property ($rose(RSTN_I) |-> SP_O == 8'h07)
      else $error("stack pointer wrong after reset");
   a_sp_write: assert property (OP_I == SRS_OP_DIRECT && WR_I && ADDR_I == 8'h81 |=> SP_O == $past(WDATA_I))
      else $error("stack pointer write lost");
   a_push_rises: assert property (OP_I == SRS_OP_PUSH |=> SP_O == $past(SP_O) + 8'h01)
      else $error("push did not raise stack pointer");
   a_pop_falls: assert property (OP_I == SRS_OP_POP |=> SP_O == $past(SP_O) - 8'h01)
      else $error("pop did not lower stack pointer");
   a_sp_idle: assert property (OP_I == SRS_OP_NONE |=> $stable(SP_O))
      else $error("stack pointer moved while idle");
   a_bank_write: assert property (OP_I == SRS_OP_DIRECT && WR_I && ADDR_I == 8'hd0 |=> BANK_O == bank_wr_q)
      else $error("bank select not taken from status word");
   a_bank_source: assert property ($changed(BANK_O) |-> psw_wr_q)
      else $error("bank changed without status word write");
   a_rbit_byte: assert property (OP_I != SRS_OP_BIT |=> !RBIT_O)
      else $error("bit answer on byte access");
   a_ram_noerr: assert property ((OP_I == SRS_OP_DIRECT || OP_I == SRS_OP_BIT) && !ADDR_I[7] |=> !ERR_O)
      else $error("error on lower scratchpad access");
   a_indir_ok: assert property (OP_I inside {SRS_OP_INDIR, SRS_OP_REG, SRS_OP_PUSH, SRS_OP_POP} |=> !ERR_O)
      else $error("error on scratchpad only access");
   a_unmapped: assert property (OP_I == SRS_OP_DIRECT && ADDR_I == 8'h80 |=> ERR_O)
      else $error("unmapped peripheral address not flagged");
endmodule
bind srs_top srs_top_chk chk (.CORE_CLK_I, .RSTN_I, .OP_I, .WR_I, .ADDR_I, .WDATA_I, .RBIT_O, .ERR_O, .SP_O, .BANK_O);
`default_nettype wire

// file: verification/srs_cpu_model.sv
// Execution unit model issuing one access at a time
`timescale 1ns/1ps
`default_nettype none
module srs_cpu_model
   import srs_pkg::*;
(
   // Clock
   input  wire logic      clk_i,
   // Request
   output srs_op_e        op_o,
   output logic           wr_o,
   output srs_byte_t      addr_o,
   output logic [2:0]     reg_o,
   output srs_byte_t      wdata_o,
   output logic           bit_o,
   // Answer
   input  wire srs_byte_t rdata_i,
   input  wire logic      rbit_i,
   input  wire logic      err_i
);
   srs_byte_t rd;
   logic      rb;
   logic      er;
   initial begin
      op_o = SRS_OP_NONE;
      {wr_o, addr_o, reg_o, wdata_o, bit_o} = '0;
   end
   // Answer sampled 1 ns after the taking edge
   task automatic access(input srs_op_e o, input logic w, input srs_byte_t a,
                         input logic [2:0] r, input srs_byte_t d, input logic b);
      @(posedge clk_i);
      #1;
      op_o = o;
      {wr_o, addr_o, reg_o, wdata_o, bit_o} = {w, a, r, d, b};
      @(posedge clk_i);
      #1;
      op_o = SRS_OP_NONE;
      {wr_o, addr_o, wdata_o} = {1'b0, ~addr_o, ~wdata_o};
      {rd, rb, er} = {rdata_i, rbit_i, err_i};
   endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the scratchpad register space
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb
   import srs_pkg::*;
;
   logic       clk;
   logic       rst_n;
   srs_op_e    op;
   logic       wr;
   srs_byte_t  addr;
   logic [2:0] rsel;
   srs_byte_t  wdata;
   logic       bitv;
   srs_byte_t  rdata;
   srs_byte_t  sp;
   logic       rbit;
   logic       err;
   logic [1:0] bank;
   int         miscompares;
   int         n_compared;
   srs_top uut (.CORE_CLK_I(clk), .RSTN_I(rst_n), .OP_I(op), .WR_I(wr), .ADDR_I(addr), .REG_I(rsel), .WDATA_I(wdata),
                .BIT_I(bitv), .RDATA_O(rdata), .RBIT_O(rbit), .ERR_O(err), .SP_O(sp), .BANK_O(bank));
   srs_cpu_model cpu (.clk_i(clk), .op_o(op), .wr_o(wr), .addr_o(addr), .reg_o(rsel), .wdata_o(wdata), .bit_o(bitv),
                      .rdata_i(rdata), .rbit_i(rbit), .err_i(err));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic dw(input srs_byte_t a, input srs_byte_t d);
      cpu.access(SRS_OP_DIRECT, 1'b1, a, 3'h0, d, 1'b0);
   endtask
   task automatic dr(input srs_byte_t a);
      cpu.access(SRS_OP_DIRECT, 1'b0, a, 3'h0, 8'h00, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK(sp, 8'h07)
      dr(8'h81);
      `CHK(cpu.rd, 8'h07)
      dr(8'h90);
      `CHK(cpu.rd, 8'hff)
      dr(8'h80);
      `CHK(cpu.er, 1'b1)
   endtask
   task automatic t_bits();
      dw(8'h0f, 8'h5a);
      cpu.access(SRS_OP_BIT, 1'b1, 8'h0f, 3'h0, 8'h00, 1'b1);
      dr(8'h21);
      `CHK(cpu.rd, 8'h80)
      dr(8'h0f);
      `CHK(cpu.rd, 8'h5a)
      dw(8'h2f, 8'h81);
      for (int i = 0; i < 8; i++) begin
         cpu.access(SRS_OP_BIT, 1'b0, 8'(8'h78 + i), 3'h0, 8'h00, 1'b0);
         `CHK(cpu.rb, (i == 0 || i == 7))
      end
   endtask
   task automatic t_sfr_bit();
      cpu.access(SRS_OP_BIT, 1'b1, 8'hd3, 3'h0, 8'h00, 1'b1);
      `CHK(bank, 2'b01)
      cpu.access(SRS_OP_BIT, 1'b1, 8'he5, 3'h0, 8'h00, 1'b1);
      dr(8'he0);
      `CHK(cpu.rd, 8'h20)
      // Bit address 89h lands in byte 88h, bit 1
      cpu.access(SRS_OP_BIT, 1'b1, 8'h89, 3'h0, 8'h00, 1'b1);
      dr(8'h88);
      `CHK(cpu.rd, 8'h02)
      dr(8'h89);
      `CHK(cpu.rd, 8'h00)
   endtask
   task automatic t_bank();
      for (int b = 0; b < 4; b++) begin
         dw(8'hd0, 8'(b << 3));
         `CHK(bank, 2'(b))
         cpu.access(SRS_OP_REG, 1'b1, 8'h00, 3'h2, 8'(8'h10 + b), 1'b0);
      end
      cpu.access(SRS_OP_REG, 1'b0, 8'h00, 3'h2, 8'h00, 1'b0);
      `CHK(cpu.rd, 8'h13)
      for (int b = 0; b < 4; b++) begin
         dr(8'(b * 8 + 2));
         `CHK(cpu.rd, 8'(8'h10 + b))
      end
   endtask
   task automatic t_indir();
      dw(8'hd0, 8'h00);
      cpu.access(SRS_OP_REG, 1'b1, 8'h00, 3'h1, 8'h90, 1'b0);
      cpu.access(SRS_OP_INDIR, 1'b1, 8'h00, 3'h1, 8'h3c, 1'b0);
      dr(8'h90);
      `CHK(cpu.rd, 8'hff)
      cpu.access(SRS_OP_INDIR, 1'b0, 8'h00, 3'h1, 8'h00, 1'b0);
      `CHK(cpu.rd, 8'h3c)
   endtask
   task automatic t_stack();
      dw(8'h81, 8'hc0);
      `CHK(sp, 8'hc0)
      // Return address, low byte first
      cpu.access(SRS_OP_PUSH, 1'b0, 8'h00, 3'h0, 8'h34, 1'b0);
      cpu.access(SRS_OP_PUSH, 1'b0, 8'h00, 3'h0, 8'h12, 1'b0);
      `CHK(sp, 8'hc2)
      cpu.access(SRS_OP_REG, 1'b1, 8'h00, 3'h0, 8'hc1, 1'b0);
      cpu.access(SRS_OP_INDIR, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0);
      `CHK(cpu.rd, 8'h34)
      cpu.access(SRS_OP_POP, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0);
      `CHK(cpu.rd, 8'h12)
      cpu.access(SRS_OP_POP, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0);
      `CHK(sp, 8'hc0)
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_bits();
      t_sfr_bit();
      t_bank();
      t_indir();
      t_stack();
      print_verdict();
   end
endmodule
`default_nettype wire
